//--- rtl/gpf_pkg.sv
package gpf_pkg;
  // register map
  localparam logic [8:0] GAUGE_CFG_ADDR  = 9'h029;
  localparam logic [8:0] FLAGS_HIGH_ADDR = 9'h02a;
  localparam logic [8:0] FLAGS_LOW_ADDR  = 9'h02b;
  localparam logic [8:0] PF_SETUP_ADDR   = 9'h11f;
  localparam logic [8:0] EXTRA_LOW_ADDR  = 9'h139;
  localparam logic [8:0] STATUS_ADDR     = 9'h1f0;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  // gauge config bits
  localparam int EDV_BASIS_BIT  = 3;
  localparam int OV_BASIS_BIT   = 2;
  localparam int CONT_FIX_BIT   = 1;
  localparam int ONE_SHOT_BIT   = 0;
  // high flag bits (b15..b8 held as 7..0)
  localparam int INT_TEMP_BIT   = 7;
  localparam int FE_CHECK_BIT   = 5;
  localparam int SLEEP_DIS_BIT  = 4;
  localparam int OT_ACTION_BIT  = 3;
  localparam int CHG_LED_BIT    = 2;
  localparam int FLAG_DELAY_BIT = 0;
  // low flag bits
  localparam int ALARM_LED_BIT  = 7;
  localparam int PRE_HI_BIT     = 6;
  localparam int PRE_LO_BIT     = 5;
  localparam int FIXED_PACK_BIT = 4;
  localparam int CHG_HOLD_BIT   = 3;
  localparam int DSG_HOT_BIT    = 0;
  // extra flag bits
  localparam int LONG_NAME_BIT  = 5;
  localparam int CMD_REMAP_BIT  = 4;
  localparam int CUR_OVR_BIT    = 3;
  localparam int LEVEL_CAP_BIT  = 2;
  localparam int VOLT_OVR_BIT   = 1;
  localparam int DEPLETED_BIT   = 0;
  localparam int PF_FE_BIT      = 3;
  // limits and codes
  localparam logic [4:0] MFR_LEN_LONG  = 5'd26;
  localparam logic [4:0] DEV_LEN_LONG  = 5'd22;
  localparam logic [4:0] MFR_LEN_SHORT = 5'd11;
  localparam logic [4:0] DEV_LEN_SHORT = 5'd7;
  localparam logic [7:0] CELL_CMD_BASE  = 8'h3c;
  localparam logic [7:0] CELL_CMD_REMAP = 8'h38;
  localparam logic [6:0] LEVEL_CAP      = 7'h63;
  // timing
  localparam int CLK_HZ        = 25000000;
  localparam int SLEEP_TIME_MS = 2000;
  localparam int DELAY_TIME_MS = 1000;
  localparam int SLEEP_CYCLES  = SLEEP_TIME_MS * (CLK_HZ / 1000);
  localparam int DELAY_CYCLES  = DELAY_TIME_MS * (CLK_HZ / 1000);
  localparam int FAULT_CYCLES  = DELAY_CYCLES;

  typedef enum logic [1:0] {
    GPF_PRE_ZERO_VOLT = 2'b00,
    GPF_PRE_CHARGE    = 2'b01,
    GPF_PRE_FRONT_END = 2'b10,
    GPF_PRE_UNDEFINED = 2'b11
  } gpf_pre_e;

  // measurements and reported values from the gauge core
  typedef struct packed {
    logic [15:0] lowest_cell_mv;
    logic [15:0] highest_cell_mv;
    logic [15:0] pack_mv;
    logic [15:0] end_of_discharge_voltage;
    logic [15:0] safety_mv;
    logic [15:0] precharge_mv;
    logic [2:0]  cell_count;
    logic [15:0] int_temp;
    logic [15:0] ext_temp;
    logic [15:0] chg_current;
    logic [15:0] chg_voltage;
    logic [6:0]  relative_charge_level;
    logic [6:0]  absolute_charge_level;
  } gpf_meas_s;

  // gauge events, all levels on sys_clk
  typedef struct packed {
    logic discharge_state_bit;
    logic fully_charged_bit;
    logic overtemp;
    logic cell_ov_raw;
    logic cell_uv_raw;
    logic capacity_alarm;
    logic charge_term;
    logic chg_fail;
    logic dsg_fail;
    logic pack_removed;
    logic opposite_current;
    logic avg_below_clear;
    logic depleted;
    logic precharge_req;
    logic afe_comm_err;
  } gpf_event_s;

  // switch controls
  typedef struct packed {
    logic chg_fet_on;
    logic dsg_fet_on;
    logic zero_volt_charge_switch;
    logic front_end_precharge_switch;
  } gpf_fet_s;
endpackage

//--- rtl/gpf_sync3.sv
`timescale 1ns/10ps
// three-stage pin synchroniser; output moves when stages two and three agree
module gpf_sync3 (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

//--- rtl/gpf_hold_timer.sv
`timescale 1ns/10ps
// raises done once cond has held for COUNT cycles; drops with cond
module gpf_hold_timer #(
  parameter int COUNT = 16
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic cond,
  output logic      done
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
  logic [CW-1:0] count;

  // count while held, saturate at the end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!cond) begin
      count <= '0;
      done  <= 1'b0;
    end else if (count == LAST) begin
      done <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

//--- rtl/gpf_policy_regs.sv
`timescale 1ns/10ps
module gpf_policy_regs #(
  parameter int SLEEP_CNT = gpf_pkg::SLEEP_CYCLES,
  parameter int DELAY_CNT = gpf_pkg::DELAY_CYCLES,
  parameter int FAULT_CNT = gpf_pkg::FAULT_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic [8:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  input  wire logic               smbus_clk_pin,
  input  wire logic               smbus_data_pin,
  input  wire gpf_pkg::gpf_meas_s meas,
  input  wire gpf_pkg::gpf_event_s ev,
  input  wire logic [7:0]         cmd_code,
  output gpf_pkg::gpf_fet_s       fet,
  output logic                    edv_reached,
  output logic                    safety_ov,
  output logic                    midrange_fix_req,
  output logic [15:0]             temp_out,
  output logic                    afe_check_en,
  output logic                    afe_pf_en,
  output logic                    afe_comm_fault,
  output logic                    sleep_req,
  output logic                    led_on,
  output logic                    led_blink,
  output logic                    cell_overvoltage_flag,
  output logic                    cell_undervoltage_flag,
  output logic                    fail_active,
  output logic [4:0]              mfr_name_max,
  output logic [4:0]              dev_name_max,
  output logic                    cell_cmd_hit,
  output logic [1:0]              cell_cmd_index,
  output logic [15:0]             rpt_chg_current,
  output logic [15:0]             rpt_chg_voltage,
  output logic [6:0]              rpt_relative_level,
  output logic [6:0]              rpt_absolute_level
);
  import gpf_pkg::*;

  // configuration bytes as written by software
  logic [7:0] gauge_cfg;
  logic [7:0] feature_flags_high;
  logic [7:0] feature_flags_low;
  logic [7:0] extra_feature_flags_low;
  logic [7:0] permanent_failure_setup;

  // latched policy state
  logic       one_shot_done;
  logic       chg_fail_held;
  logic       dsg_fail_held;
  logic       term_seen;

  // named configuration fields
  wire end_discharge_basis_sel  = gauge_cfg[EDV_BASIS_BIT];
  wire safety_overvoltage_basis = gauge_cfg[OV_BASIS_BIT];
  wire continuous_midrange_fix  = gauge_cfg[CONT_FIX_BIT];
  wire one_shot_midrange_fix    = gauge_cfg[ONE_SHOT_BIT];

  // high flag byte
  wire internal_temp_sensor_sel = feature_flags_high[INT_TEMP_BIT];
  wire front_end_comm_check     = feature_flags_high[FE_CHECK_BIT];
  wire sleep_disable            = feature_flags_high[SLEEP_DIS_BIT];
  wire overtemp_fet_action      = feature_flags_high[OT_ACTION_BIT];
  wire charging_led_enable      = feature_flags_high[CHG_LED_BIT];
  wire cell_flag_delay          = feature_flags_high[FLAG_DELAY_BIT];

  // low flag byte
  wire alarm_led_style          = feature_flags_low[ALARM_LED_BIT];
  wire fixed_pack_mode          = feature_flags_low[FIXED_PACK_BIT];
  wire charge_switch_hold       = feature_flags_low[CHG_HOLD_BIT];
  wire discharge_switch_hold_hot = feature_flags_low[DSG_HOT_BIT];

  // extra flag byte
  wire long_name_enable         = extra_feature_flags_low[LONG_NAME_BIT];
  wire cell_command_remap       = extra_feature_flags_low[CMD_REMAP_BIT];
  wire charge_current_override  = extra_feature_flags_low[CUR_OVR_BIT];
  wire charge_level_cap         = extra_feature_flags_low[LEVEL_CAP_BIT];
  wire charge_voltage_override  = extra_feature_flags_low[VOLT_OVR_BIT];
  wire depleted_charge_switch_on = extra_feature_flags_low[DEPLETED_BIT];

  // precharge switch code
  wire precharge_sel_hi         = feature_flags_low[PRE_HI_BIT];
  wire precharge_sel_lo         = feature_flags_low[PRE_LO_BIT];
  gpf_pre_e pre_sel;
  assign pre_sel = gpf_pre_e'({precharge_sel_hi, precharge_sel_lo});

  // register bus decode
  wire sel_gauge  = reg_addr == GAUGE_CFG_ADDR;
  wire sel_high   = reg_addr == FLAGS_HIGH_ADDR;
  wire sel_low    = reg_addr == FLAGS_LOW_ADDR;
  wire sel_pf     = reg_addr == PF_SETUP_ADDR;
  wire sel_extra  = reg_addr == EXTRA_LOW_ADDR;
  wire sel_status = reg_addr == STATUS_ADDR;

  // bus pin synchronisers, sleep timer and cell flag and fault hold timers
  logic scl_level;
  logic sda_level;
  logic bus_idle_done;
  logic ov_delay_done;
  logic uv_delay_done;
  logic low_current_done;

  // timer start conditions
  wire bus_low       = !scl_level && !sda_level;
  wire ov_raw_held   = ev.cell_ov_raw;
  wire uv_raw_held   = ev.cell_uv_raw;
  wire fail_low_curr = ev.avg_below_clear && (chg_fail_held || dsg_fail_held);

  gpf_sync3 u_sync_scl (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (smbus_clk_pin),
    .level   (scl_level)
  );

  gpf_sync3 u_sync_sda (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (smbus_data_pin),
    .level   (sda_level)
  );

  gpf_hold_timer #(.COUNT(SLEEP_CNT)) u_sleep_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (bus_low),
    .done    (bus_idle_done)
  );

  gpf_hold_timer #(.COUNT(DELAY_CNT)) u_ov_delay (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (ov_raw_held),
    .done    (ov_delay_done)
  );

  gpf_hold_timer #(.COUNT(DELAY_CNT)) u_uv_delay (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (uv_raw_held),
    .done    (uv_delay_done)
  );

  gpf_hold_timer #(.COUNT(FAULT_CNT)) u_fault_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (fail_low_curr),
    .done    (low_current_done)
  );

  // voltage judgements
  wire [15:0] edv_source   = end_discharge_basis_sel ? meas.pack_mv : meas.lowest_cell_mv;
  wire [18:0] cell_product = meas.highest_cell_mv * meas.cell_count;
  wire [18:0] ov_source    = safety_overvoltage_basis ? cell_product : {3'h0, meas.pack_mv};

  // threshold compares
  wire next_edv_reached    = edv_source < meas.end_of_discharge_voltage;
  wire next_safety_ov      = ov_source > {3'h0, meas.safety_mv};

  // midrange correction requests
  wire one_shot_fire = one_shot_midrange_fix && !one_shot_done;
  wire next_midrange = continuous_midrange_fix || one_shot_fire;

  // temperature source and front-end checking
  wire [15:0] next_temp = internal_temp_sensor_sel ? meas.int_temp : meas.ext_temp;
  wire next_pf_en       = front_end_comm_check && permanent_failure_setup[PF_FE_BIT];
  wire next_sleep       = !sleep_disable && bus_idle_done;

  // capacity display
  wire leds_allowed   = ev.discharge_state_bit || charging_led_enable;
  wire alarm_dark     = ev.capacity_alarm && alarm_led_style;
  wire next_led_on    = leds_allowed && !alarm_dark;
  wire next_led_blink = next_led_on && ev.capacity_alarm;

  // cell flags, optionally held back
  wire next_cell_ov = cell_flag_delay ? ov_delay_done : ev.cell_ov_raw;
  wire next_cell_uv = cell_flag_delay ? uv_delay_done : ev.cell_uv_raw;

  // failure clearing
  wire fixed_clear = fixed_pack_mode && (ev.opposite_current || low_current_done);
  wire fail_clear  = ev.pack_removed || fixed_clear;
  wire next_chg_fail = ev.chg_fail || (chg_fail_held && !fail_clear);
  wire next_dsg_fail = ev.dsg_fail || (dsg_fail_held && !fail_clear);
  wire next_term     = ev.charge_term || (term_seen && !ev.discharge_state_bit && !ev.pack_removed);

  // switch decisions
  wire ot_hit      = overtemp_fet_action && ev.overtemp;
  wire in_charge   = !ev.discharge_state_bit;
  wire ot_dsg_off  = ot_hit && !(in_charge && discharge_switch_hold_hot);

  // failure shut-off, opposite switch kept in fixed pack
  wire fail_chg_off = chg_fail_held || (dsg_fail_held && !fixed_pack_mode);
  wire fail_dsg_off = dsg_fail_held || (chg_fail_held && !fixed_pack_mode);

  // termination, depleted and precharge
  wire term_off    = term_seen && !charge_switch_hold;
  wire dep_on      = depleted_charge_switch_on && ev.depleted
                     && (meas.lowest_cell_mv > meas.precharge_mv);
  wire pre_chg     = ev.precharge_req && (pre_sel == GPF_PRE_CHARGE);
  wire chg_normal  = !ot_hit && !fail_chg_off && !term_off && !ev.precharge_req;

  // next switch states
  gpf_fet_s next_fet;
  assign next_fet.chg_fet_on = dep_on || pre_chg || chg_normal;
  assign next_fet.dsg_fet_on = !ot_dsg_off && !fail_dsg_off;
  assign next_fet.zero_volt_charge_switch = ev.precharge_req && (pre_sel == GPF_PRE_ZERO_VOLT);
  assign next_fet.front_end_precharge_switch = ev.precharge_req && (pre_sel == GPF_PRE_FRONT_END);

  // command mapping and name lengths
  wire [7:0] cell_base  = cell_command_remap ? CELL_CMD_REMAP : CELL_CMD_BASE;
  wire next_cmd_hit     = cmd_code[7:2] == cell_base[7:2];
  wire [4:0] next_mfr   = long_name_enable ? MFR_LEN_LONG : MFR_LEN_SHORT;
  wire [4:0] next_dev   = long_name_enable ? DEV_LEN_LONG : DEV_LEN_SHORT;

  // other registered outputs
  wire       next_afe_fault   = front_end_comm_check && ev.afe_comm_err;
  wire       next_fail_active = chg_fail_held || dsg_fail_held;
  wire [1:0] next_index       = cmd_code[1:0];

  // reporting overrides
  wire zero_cur  = charge_current_override && ev.discharge_state_bit;
  wire zero_volt = charge_voltage_override && ev.fully_charged_bit;

  // level cap until a valid termination
  wire cap_on    = charge_level_cap && !term_seen;
  wire [6:0] cap_rel = (meas.relative_charge_level > LEVEL_CAP) ? LEVEL_CAP : meas.relative_charge_level;
  wire [6:0] cap_abs = (meas.absolute_charge_level > LEVEL_CAP) ? LEVEL_CAP : meas.absolute_charge_level;

  // status and read selection
  wire [7:0] status_word = {1'b0, sleep_req, one_shot_done, term_seen,
                            dsg_fail_held, chg_fail_held,
                            cell_undervoltage_flag, cell_overvoltage_flag};

  // read mux, zero outside the answer cycle
  wire [7:0] next_rdata = !reg_rd     ? 8'h00 :
                          sel_gauge   ? gauge_cfg :
                          sel_high    ? feature_flags_high :
                          sel_low     ? feature_flags_low :
                          sel_pf      ? permanent_failure_setup :
                          sel_extra   ? extra_feature_flags_low :
                          sel_status  ? status_word : 8'h00;

  // configuration writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gauge_cfg               <= CFG_RESET;
      feature_flags_high      <= CFG_RESET;
      feature_flags_low       <= CFG_RESET;
      extra_feature_flags_low <= CFG_RESET;
      permanent_failure_setup <= CFG_RESET;
    end else if (reg_wr) begin
      if (sel_gauge) gauge_cfg <= reg_wdata;
      if (sel_high) feature_flags_high <= reg_wdata;
      if (sel_low) feature_flags_low <= reg_wdata;
      if (sel_pf) permanent_failure_setup <= reg_wdata;
      if (sel_extra) extra_feature_flags_low <= reg_wdata;
    end
  end

  // internal state; a new failure beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      one_shot_done <= 1'b0;
      chg_fail_held <= 1'b0;
      dsg_fail_held <= 1'b0;
      term_seen     <= 1'b0;
    end else begin
      one_shot_done <= one_shot_done || one_shot_fire;
      chg_fail_held <= next_chg_fail;
      dsg_fail_held <= next_dsg_fail;
      term_seen     <= next_term;
    end
  end

  // judgement and control outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata        <= 8'h00;
      fet              <= '0;
      edv_reached      <= 1'b0;
      safety_ov        <= 1'b0;
      midrange_fix_req <= 1'b0;
      temp_out         <= 16'h0000;
    end else begin
      reg_rdata        <= next_rdata;
      fet              <= next_fet;
      edv_reached      <= next_edv_reached;
      safety_ov        <= next_safety_ov;
      midrange_fix_req <= next_midrange;
      temp_out         <= next_temp;
    end
  end

  // front-end, sleep and display outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      afe_check_en     <= 1'b0;
      afe_pf_en        <= 1'b0;
      afe_comm_fault   <= 1'b0;
      sleep_req        <= 1'b0;
      led_on           <= 1'b0;
      led_blink        <= 1'b0;
    end else begin
      afe_check_en     <= front_end_comm_check;
      afe_pf_en        <= next_pf_en;
      afe_comm_fault   <= next_afe_fault;
      sleep_req        <= next_sleep;
      led_on           <= next_led_on;
      led_blink        <= next_led_blink;
    end
  end

  // flags, map and reported values
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_overvoltage_flag  <= 1'b0;
      cell_undervoltage_flag <= 1'b0;
      fail_active            <= 1'b0;
      mfr_name_max           <= MFR_LEN_SHORT;
      dev_name_max           <= DEV_LEN_SHORT;
      cell_cmd_hit           <= 1'b0;
      cell_cmd_index         <= 2'b00;
      rpt_chg_current        <= 16'h0000;
      rpt_chg_voltage        <= 16'h0000;
      rpt_relative_level     <= 7'h00;
      rpt_absolute_level     <= 7'h00;
    end else begin
      cell_overvoltage_flag  <= next_cell_ov;
      cell_undervoltage_flag <= next_cell_uv;
      fail_active            <= next_fail_active;
      mfr_name_max           <= next_mfr;
      dev_name_max           <= next_dev;
      cell_cmd_hit           <= next_cmd_hit;
      cell_cmd_index         <= next_index;
      rpt_chg_current        <= zero_cur ? 16'h0000 : meas.chg_current;
      rpt_chg_voltage        <= zero_volt ? 16'h0000 : meas.chg_voltage;
      rpt_relative_level     <= cap_on ? cap_rel : meas.relative_charge_level;
      rpt_absolute_level     <= cap_on ? cap_abs : meas.absolute_charge_level;
    end
  end
endmodule

//--- testbench/gpf_policy_monitor.sv
`timescale 1ns/10ps
// checks policy outputs against a shadow copy of the config bytes
module gpf_policy_monitor (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic [8:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire gpf_pkg::gpf_meas_s  meas,
  input wire gpf_pkg::gpf_event_s ev,
  input wire logic [7:0]          cmd_code,
  input wire gpf_pkg::gpf_fet_s   fet,
  input wire logic                edv_reached,
  input wire logic                safety_ov,
  input wire logic [15:0]         temp_out,
  input wire logic                sleep_req,
  input wire logic                led_on,
  input wire logic [4:0]          mfr_name_max,
  input wire logic                cell_cmd_hit,
  input wire logic [15:0]         rpt_chg_current,
  input wire logic [15:0]         rpt_chg_voltage
);
  import gpf_pkg::*;
  logic [7:0] gcfg, hi, lo, ext;
  logic       up;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // shadow bytes follow writes; up masks the first edge after reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {gcfg, hi, lo, ext, up} <= '0;
    end else begin
      up <= 1'b1;
      if (reg_wr && reg_addr == GAUGE_CFG_ADDR) gcfg <= reg_wdata;
      if (reg_wr && reg_addr == FLAGS_HIGH_ADDR) hi <= reg_wdata;
      if (reg_wr && reg_addr == FLAGS_LOW_ADDR) lo <= reg_wdata;
      if (reg_wr && reg_addr == EXTRA_LOW_ADDR) ext <= reg_wdata;
    end
  end
  // sleep disable held over two edges
  sequence s_ds_held;
    hi[SLEEP_DIS_BIT] ##1 hi[SLEEP_DIS_BIT];
  endsequence
  edv_basis_a: assert property (up && !$past(gcfg[EDV_BASIS_BIT]) |-> edv_reached ==
    ($past(meas.lowest_cell_mv) < $past(meas.end_of_discharge_voltage))) else $error("edv level wrong");
  ov_basis_a: assert property (up && !$past(gcfg[OV_BASIS_BIT]) |-> safety_ov ==
    ($past(meas.pack_mv) > $past(meas.safety_mv))) else $error("safety ov wrong");
  temp_source_a: assert property (up |-> temp_out ==
    ($past(hi[INT_TEMP_BIT]) ? $past(meas.int_temp) : $past(meas.ext_temp))) else $error("temp source wrong");
  no_sleep_a: assert property (s_ds_held |=> !sleep_req) else $error("sleep while disabled");
  alarm_led_a: assert property (up && $past(lo[ALARM_LED_BIT]) && $past(ev.capacity_alarm) |->
    !led_on) else $error("led lit in alarm");
  zero_volt_a: assert property (up && $past(ev.precharge_req) &&
    $past(lo[PRE_HI_BIT:PRE_LO_BIT]) == GPF_PRE_ZERO_VOLT |-> fet.zero_volt_charge_switch &&
    !fet.front_end_precharge_switch) else $error("precharge switch wrong");
  name_len_a: assert property (up |-> mfr_name_max ==
    ($past(ext[LONG_NAME_BIT]) ? MFR_LEN_LONG : MFR_LEN_SHORT)) else $error("name length wrong");
  cell_map_a: assert property (up |-> cell_cmd_hit == ($past(cmd_code[7:2]) ==
    ($past(ext[CMD_REMAP_BIT]) ? CELL_CMD_REMAP[7:2] : CELL_CMD_BASE[7:2]))) else $error("cell map wrong");
  cur_zero_a: assert property (up && $past(ext[CUR_OVR_BIT]) && $past(ev.discharge_state_bit) |->
    rpt_chg_current == 16'h0000) else $error("current not zeroed");
  volt_zero_a: assert property (up && $past(ext[VOLT_OVR_BIT]) && $past(ev.fully_charged_bit) |->
    rpt_chg_voltage == 16'h0000) else $error("voltage not zeroed");
endmodule
bind gpf_policy_regs gpf_policy_monitor i_mon (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .meas,
  .ev, .cmd_code, .fet, .edv_reached, .safety_ov, .temp_out, .sleep_req, .led_on, .mfr_name_max,
  .cell_cmd_hit, .rpt_chg_current, .rpt_chg_voltage);

//--- testbench/gpf_bus_host.sv
`timescale 1ns/10ps
// bus host stand-in: lines rest at the pull-up level unless held low
module gpf_bus_host (
  input  wire logic hold_low,
  output logic      smbus_clk_pin,
  output logic      smbus_data_pin
);
  // released lines return to the pull-up
  assign smbus_clk_pin  = !hold_low;
  assign smbus_data_pin = !hold_low;
endmodule

//--- testbench/test_gauge_policy_config_flags.sv
`timescale 1ns/10ps
module test_gauge_policy_config_flags;
  import gpf_pkg::*;
  logic        sys_clk, reset_n, reg_wr, reg_rd, hold_low, smbus_clk_pin, smbus_data_pin;
  logic        edv_reached, safety_ov, sleep_req, led_on, cell_cmd_hit;
  logic        midrange_fix_req, afe_pf_en, cell_overvoltage_flag;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cmd_code;
  logic [15:0] temp_out, rpt_chg_current, rpt_chg_voltage;
  logic [6:0]  rpt_relative_level, rpt_absolute_level;
  logic [4:0]  mfr_name_max, dev_name_max;
  logic [1:0]  cell_cmd_index, code;
  gpf_meas_s   meas;
  gpf_event_s  ev;
  gpf_fet_s    fet;
  int          mismatches, checks, n;
  // short timer counts keep the run brief
  gpf_policy_regs #(.SLEEP_CNT(8), .DELAY_CNT(8), .FAULT_CNT(8)) i_dut (.sys_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .smbus_clk_pin, .smbus_data_pin, .meas, .ev, .cmd_code, .fet,
    .edv_reached, .safety_ov, .midrange_fix_req, .temp_out, .afe_check_en(), .afe_pf_en,
    .afe_comm_fault(), .sleep_req, .led_on, .led_blink(), .cell_overvoltage_flag,
    .cell_undervoltage_flag(), .fail_active(), .mfr_name_max, .dev_name_max, .cell_cmd_hit,
    .cell_cmd_index, .rpt_chg_current, .rpt_chg_voltage, .rpt_relative_level, .rpt_absolute_level);
  gpf_bus_host i_host (.hold_low, .smbus_clk_pin, .smbus_data_pin);
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  // compare, count and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write and read strobes
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic ext_case(input logic [7:0] v);
    wr(EXTRA_LOW_ADDR, v);
    cmd_code <= v[4] ? 8'h3b : 8'h3c;
    settle();
    chk(16'(mfr_name_max), v[5] ? 16'd26 : 16'd11);
    chk(16'(dev_name_max), v[5] ? 16'd22 : 16'd7);
    chk(16'({cell_cmd_hit, cell_cmd_index}), v[4] ? 16'h7 : 16'h4);
    chk(rpt_chg_current, v[3] ? 16'h0 : 16'h1234);
    chk(rpt_chg_voltage, v[1] ? 16'h0 : 16'h5678);
    chk(16'(rpt_relative_level), v[2] ? 16'd99 : 16'd100);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, hold_low, reg_addr, reg_wdata, cmd_code, meas, ev} = '0;
    meas.lowest_cell_mv = 16'd3000;
    meas.end_of_discharge_voltage = 16'd3100;
    meas.highest_cell_mv = 16'd3000;
    meas.cell_count = 3'd3;
    meas.pack_mv = 16'd12000;
    meas.safety_mv = 16'd11000;
    meas.int_temp = 16'h0aaa;
    meas.ext_temp = 16'h0555;
    meas.chg_current = 16'h1234;
    meas.chg_voltage = 16'h5678;
    meas.relative_charge_level = 7'd100;
    ev = '{discharge_state_bit: 1'b1, fully_charged_bit: 1'b1, precharge_req: 1'b1, capacity_alarm: 1'b1,
      default: 1'b0};
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(FLAGS_HIGH_ADDR, 8'h00);
    rd(FLAGS_LOW_ADDR, 8'h00);
    rd(EXTRA_LOW_ADDR, 8'h00);
    wr(FLAGS_HIGH_ADDR, 8'h82);
    rd(FLAGS_HIGH_ADDR, 8'h82);
    rd(9'h0ff, 8'h00);
    chk(temp_out, 16'h0aaa);
    wr(FLAGS_HIGH_ADDR, 8'h02);
    settle();
    chk(temp_out, 16'h0555);
    $display("test registers and temperature done");
    wr(GAUGE_CFG_ADDR, 8'h00);
    settle();
    chk(16'({edv_reached, safety_ov}), 16'h3);
    wr(GAUGE_CFG_ADDR, 8'h0c);
    settle();
    chk(16'({edv_reached, safety_ov}), 16'h0);
    $display("test voltage basis done");
    for (int c = 0; c < 3; c++) begin
      code = 2'(c);
      wr(FLAGS_LOW_ADDR, {code[1], code, 5'h00});
      settle();
      chk(16'({fet.zero_volt_charge_switch, fet.chg_fet_on, fet.front_end_precharge_switch}),
        16'({code == 2'd0, code == 2'd1, code == 2'd2}));
    end
    $display("test precharge done");
    ext_case(8'h00);
    ext_case(8'h3e);
    ev.discharge_state_bit <= 1'b0;
    ev.charge_term <= 1'b1;
    settle();
    chk(16'({rpt_relative_level, rpt_absolute_level}), 16'({7'd100, 7'd0}));
    $display("test extra flags done");
    ev.precharge_req <= 1'b0;
    wr(FLAGS_LOW_ADDR, 8'h00);
    settle();
    chk(16'(fet.chg_fet_on), 16'h0);
    ev.overtemp <= 1'b1;
    wr(PF_SETUP_ADDR, 8'h08);
    wr(GAUGE_CFG_ADDR, 8'h0e);
    wr(FLAGS_LOW_ADDR, 8'h08);
    settle();
    chk(16'({fet.chg_fet_on, fet.dsg_fet_on}), 16'h3);
    wr(FLAGS_HIGH_ADDR, 8'h2b);
    ev.cell_ov_raw <= 1'b1;
    settle();
    chk(16'({fet.chg_fet_on, fet.dsg_fet_on, cell_overvoltage_flag}), 16'h0);
    chk(16'({afe_pf_en, midrange_fix_req}), 16'h3);
    wr(FLAGS_LOW_ADDR, 8'h09);
    repeat (10) @(posedge sys_clk);
    #1 chk(16'({fet.dsg_fet_on, cell_overvoltage_flag}), 16'h3);
    $display("test switch policy done");
    wr(FLAGS_HIGH_ADDR, 8'h02);
    hold_low <= 1'b1;
    for (n = 0; n < 40 && sleep_req !== 1'b1; n++) settle();
    if (n == 40) begin
      mismatches++;
      print_verdict();
    end
    chk(16'(sleep_req), 16'h1);
    wr(FLAGS_HIGH_ADDR, 8'h12);
    repeat (40) @(posedge sys_clk);
    #1 chk(16'(sleep_req), 16'h0);
    hold_low <= 1'b0;
    $display("test sleep done");
    print_verdict();
  end
endmodule
